// File: dds_pkg.sv
// Constants shared by the serial word decoder and its helpers
// Summary of operation
// - Phase register chosen by pin or bit
// - Select pins sampled by the master clock
// - Top bits 01/10 address the frequency registers
// - Full width: two writes, low then high
// - Half mode: half-pick bit picks half written
// - Top bits 00 write the control word
// - Top bits 11 load a phase register
// - Reset clears accumulation, keeps registers
// - Output valid seven cycles after reset release
// - Reset from bit or pin by source
// - Reset pin rise immediate, release sampled
// - Sleep pin or bits power down parts
// - Clock off freezes accumulator and output
// - Writes and selection still work while off
// - Clock back on resumes with pipeline latency
// - Sleep pin rise immediate, release sampled
// - Square output gated by its enable bit
// - Source bit routes comparator to square
// - Frequency register chosen by pin or bit
// - Square output undriven when disabled
// - Divide bit picks raw or halved bit
package dds_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WORD = 8'h04;
  localparam logic [7:0] ADDR_TUNING_WORD_ZERO = 8'h08;
  localparam logic [7:0] ADDR_TUNING_WORD_ONE = 8'h0c;
  localparam logic [7:0] ADDR_PHASE = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // Control word bit positions
  localparam int CB_FULL = 13;
  localparam int CB_HALF = 12;
  localparam int CB_FPICK = 11;
  localparam int CB_PPICK = 10;
  localparam int CB_SRC = 9;
  localparam int CB_RST = 8;
  localparam int CB_CLKOFF = 7;
  localparam int CB_CONVOFF = 6;
  localparam int CB_SQEN = 5;
  localparam int CB_SQSRC = 4;
  localparam int CB_SQDIV = 3;
  localparam int CB_MODE = 1;
  // Word fields and targets
  localparam int WORD_W = 16;
  localparam int HALF_W = 14;
  localparam int FREQ_W = 28;
  localparam int PH_W = 12;
  localparam int WB_PHSEL = 13;
  localparam logic [1:0] TGT_CTRL = 2'h0;
  localparam logic [1:0] TGT_F0 = 2'h1;
  localparam logic [1:0] TGT_F1 = 2'h2;
  localparam logic [1:0] TGT_PH = 2'h3;
  // Reset values and timing
  localparam logic [13:0] CTRL_RST = 14'h0000;
  localparam int RST_LAT = 7;
endpackage

// File: dds_sync2.sv
// Two-stage synchroniser for pins entering the master clock domain
`timescale 1ns/1ps
module dds_sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } sync_t;
  sync_t s_r;
  sync_t s_nxt;
  // First stage feeds only the second
  always_comb begin
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end
  // Register both stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q = s_r.stab;
endmodule

// File: dds_word_shift.sv
// Serial word assembler: 16 bits per low frame, taken on link clock fall
`timescale 1ns/1ps
module dds_word_shift (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk_s,
  input wire logic frame_sync_s,
  input wire logic serial_in_s,
  output logic [15:0] word,
  output logic word_stb
);
  // Shifter state
  typedef struct packed {
    logic sclk_d;
    logic [3:0] cnt;
    logic [15:0] sh;
    logic stb;
  } shift_t;
  shift_t s_r;
  shift_t s_nxt;
  // framing by the low frame line
  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_d = sclk_s;
    s_nxt.stb = 1'b0;
    if (frame_sync_s) begin
      // Idle frame restarts the bit count
      s_nxt.cnt = 4'h0;
    end else if (s_r.sclk_d && !sclk_s) begin
      // Falling link clock takes one bit, first bit is the top one
      s_nxt.sh = {s_r.sh[14:0], serial_in_s};
      s_nxt.cnt = s_r.cnt + 4'h1;
      s_nxt.stb = (s_r.cnt == 4'hf);
    end
  end
  // Register the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign word = s_r.sh;
  assign word_stb = s_r.stb;
endmodule

// File: dds_word_ctrl.sv
// Word decoder, register bank, select/reset/sleep control and square mux
`timescale 1ns/1ps
module dds_word_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clk,
  input wire logic frame_sync,
  input wire logic serial_in,
  input wire logic freq_pick_pin,
  input wire logic phase_pick_pin,
  input wire logic reset_pin,
  input wire logic sleep_pin,
  input wire logic comp_in,
  output logic square_out,
  output logic square_oe,
  output logic converter_off,
  output logic [11:0] phase_word,
  output logic wave_valid
);
  // Whole state of the block
  typedef struct packed {
    logic [13:0] ctrl;
    logic [27:0] f0;
    logic [27:0] f1;
    logic [11:0] ph0;
    logic [11:0] ph1;
    logic [13:0] stage;
    logic pend;
    logic pend_sel;
    logic [27:0] acc;
    logic [11:0] phase_out;
    logic msb_d;
    logic div;
    logic sq;
    logic sq_oe;
    logic dac_pd;
    logic [2:0] lat;
    logic valid;
    logic rst_hold;
    logic slp_hold;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } state_t;
  state_t s_r;
  state_t s_nxt;

  // Target field of a word
  function automatic logic [1:0] word_target(input logic [15:0] w);
    return w[15:14];
  endfunction

  // Synchronised pins
  logic sclk_s;
  logic frame_sync_s;
  logic serial_in_s;
  logic fpin_s;
  logic ppin_s;
  logic rpin_s;
  logic spin_s;
  logic comp_s;
  // Serial word from the link
  logic [15:0] ser_word;
  logic ser_stb;
  // Word chosen for decode this cycle
  logic [15:0] w;
  logic w_stb;
  // Effective controls
  logic pin_mode;
  logic rst_eff;
  logic clk_off;
  logic fpick;
  logic ppick;
  logic [27:0] f_sel;
  logic [11:0] p_sel;
  // Bus access phase and word write request
  logic acc_ph;
  logic apb_word;

  // every pin passes two flops first
  dds_sync2 #(.W(8)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({serial_clk, frame_sync, serial_in, freq_pick_pin, phase_pick_pin,
        reset_pin, sleep_pin, comp_in}),
    .q({sclk_s, frame_sync_s, serial_in_s, fpin_s, ppin_s, rpin_s, spin_s, comp_s})
  );

  // Word assembly from the serial link
  dds_word_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_s(sclk_s),
    .frame_sync_s(frame_sync_s),
    .serial_in_s(serial_in_s),
    .word(ser_word),
    .word_stb(ser_stb)
  );

  // Source selection and effective reset and sleep
  always_comb begin
    pin_mode = s_r.ctrl[dds_pkg::CB_SRC];
    // pin rise acts at once, release waits one more edge
    rst_eff = pin_mode ? (rpin_s || s_r.rst_hold) : s_r.ctrl[dds_pkg::CB_RST];
    // only software may stop the core clock
    clk_off = !pin_mode && s_r.ctrl[dds_pkg::CB_CLKOFF];
    fpick = pin_mode ? fpin_s : s_r.ctrl[dds_pkg::CB_FPICK];
    ppick = pin_mode ? ppin_s : s_r.ctrl[dds_pkg::CB_PPICK];
    f_sel = fpick ? s_r.f1 : s_r.f0;
    p_sel = ppick ? s_r.ph1 : s_r.ph0;
  end

  // Serial word wins; a bus word waits a cycle when both arrive
  always_comb begin
    acc_ph = psel && penable && !s_r.rdy;
    apb_word = acc_ph && pwrite && (paddr == dds_pkg::ADDR_WORD) && !ser_stb;
    w_stb = ser_stb || apb_word;
    w = ser_stb ? ser_word : pwdata[15:0];
  end

  // Next state
  always_comb begin
    s_nxt = s_r;
    // sampled copies hold reset and sleep for one release edge
    s_nxt.rst_hold = rpin_s;
    s_nxt.slp_hold = spin_s;
    // words decode whatever the sleep state
    if (w_stb) begin
      unique case (word_target(w))
        dds_pkg::TGT_CTRL: begin
          s_nxt.ctrl = w[13:0];
          s_nxt.pend = 1'b0;
        end
        dds_pkg::TGT_F0, dds_pkg::TGT_F1: begin
          if (s_r.ctrl[dds_pkg::CB_FULL]) begin
            // second write to the same address completes the word
            if (s_r.pend && (s_r.pend_sel == w[15])) begin
              if (w[15]) begin
                s_nxt.f1 = {w[13:0], s_r.stage};
              end else begin
                s_nxt.f0 = {w[13:0], s_r.stage};
              end
              s_nxt.pend = 1'b0;
            end else begin
              s_nxt.stage = w[13:0];
              s_nxt.pend = 1'b1;
              s_nxt.pend_sel = w[15];
            end
          end else begin
            // independent halves picked by the half bit
            s_nxt.pend = 1'b0;
            if (w[15] && s_r.ctrl[dds_pkg::CB_HALF]) begin
              s_nxt.f1[27:14] = w[13:0];
            end else if (w[15]) begin
              s_nxt.f1[13:0] = w[13:0];
            end else if (s_r.ctrl[dds_pkg::CB_HALF]) begin
              s_nxt.f0[27:14] = w[13:0];
            end else begin
              s_nxt.f0[13:0] = w[13:0];
            end
          end
        end
        dds_pkg::TGT_PH: begin
          s_nxt.pend = 1'b0;
          if (w[dds_pkg::WB_PHSEL]) begin
            s_nxt.ph1 = w[11:0];
          end else begin
            s_nxt.ph0 = w[11:0];
          end
        end
      endcase
    end
    // Core accumulation
    if (rst_eff) begin
      s_nxt.acc = '0;
      s_nxt.phase_out = '0;
      s_nxt.div = 1'b0;
      s_nxt.msb_d = 1'b0;
      s_nxt.lat = '0;
      s_nxt.valid = 1'b0;
    end else if (!clk_off) begin
      // advance only while the clock runs
      // resumes on clear, new values pass the pipeline
      s_nxt.acc = s_r.acc + f_sel;
      s_nxt.phase_out = s_r.acc[27:16] + p_sel;
      s_nxt.msb_d = s_r.phase_out[11];
      if (s_r.phase_out[11] && !s_r.msb_d) begin
        s_nxt.div = !s_r.div;
      end
      if (s_r.lat != 3'(dds_pkg::RST_LAT)) begin
        s_nxt.lat = s_r.lat + 3'h1;
      end
      s_nxt.valid = (s_nxt.lat == 3'(dds_pkg::RST_LAT));
    end
    // pin mode sleeps only the converter
    // sleep pin rise immediate, release one edge later
    s_nxt.dac_pd = pin_mode ? (spin_s || s_r.slp_hold)
                            : s_r.ctrl[dds_pkg::CB_CONVOFF];
    // square output driven only when enabled
    // enable low leaves the pin undriven
    s_nxt.sq_oe = s_r.ctrl[dds_pkg::CB_SQEN];
    if (s_r.ctrl[dds_pkg::CB_SQSRC]) begin
      s_nxt.sq = comp_s;
    end else if (s_r.ctrl[dds_pkg::CB_SQDIV]) begin
      s_nxt.sq = s_r.phase_out[11];
    end else begin
      s_nxt.sq = s_r.div;
    end
    // Bus slave: one wait state, answer registered
    s_nxt.rdy = acc_ph && (!apb_word || !ser_stb) && !(pwrite && ser_stb &&
                paddr == dds_pkg::ADDR_WORD);
    s_nxt.err = 1'b0;
    s_nxt.rdata = '0;
    if (s_nxt.rdy) begin
      unique case (paddr)
        dds_pkg::ADDR_CTRL: s_nxt.rdata = {18'h0, s_r.ctrl};
        dds_pkg::ADDR_WORD: s_nxt.rdata = '0;
        dds_pkg::ADDR_TUNING_WORD_ZERO: s_nxt.rdata = {4'h0, s_r.f0};
        dds_pkg::ADDR_TUNING_WORD_ONE: s_nxt.rdata = {4'h0, s_r.f1};
        dds_pkg::ADDR_PHASE: s_nxt.rdata = {4'h0, s_r.ph1, 4'h0, s_r.ph0};
        dds_pkg::ADDR_STAT: begin
          s_nxt.rdata = {24'h0, s_r.valid, s_r.pend, clk_off, s_r.dac_pd,
                         rst_eff, ppick, fpick, pin_mode};
        end
        default: s_nxt.err = 1'b1;
      endcase
    end
  end

  // Register the state; registers reset only with the bus reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= dds_pkg::CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign square_out = s_r.sq;
  assign square_oe = s_r.sq_oe;
  assign converter_off = s_r.dac_pd;
  assign phase_word = s_r.phase_out;
  assign wave_valid = s_r.valid;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  half_low_write_a: assert property (
    w_stb && word_target(w) == dds_pkg::TGT_F1 && !s_r.ctrl[dds_pkg::CB_FULL]
    && !s_r.ctrl[dds_pkg::CB_HALF] |=> s_r.f1[13:0] == $past(w[13:0])
    && $stable(s_r.f1[27:14]))
    else $error("low half write lost");
  full_commit_a: assert property (
    w_stb && word_target(w) == dds_pkg::TGT_F0 && s_r.ctrl[dds_pkg::CB_FULL]
    && s_r.pend && !s_r.pend_sel |=> s_r.f0 == {$past(w[13:0]), $past(s_r.stage)})
    else $error("full width commit wrong");
  full_stage_a: assert property (
    w_stb && (w[15] != w[14]) && s_r.ctrl[dds_pkg::CB_FULL]
    && !s_r.pend |=> $stable(s_r.f0) && $stable(s_r.f1) && s_r.pend)
    else $error("first half changed register");
  ctrl_write_a: assert property (
    w_stb && word_target(w) == dds_pkg::TGT_CTRL |=> s_r.ctrl == $past(w[13:0]))
    else $error("control word not stored");
  phase_load_a: assert property (
    w_stb && w[15:13] == 3'h7 |=> s_r.ph1 == $past(w[11:0]))
    else $error("phase one not loaded");
  reset_keeps_a: assert property (
    rst_eff && !w_stb |=> s_r.acc == '0 && $stable(s_r.f0) && $stable(s_r.ctrl))
    else $error("reset path wrong");
  reset_latency_a: assert property (
    $fell(rst_eff) ##0 (!rst_eff && !clk_off && !s_r.valid) [*7] |=> s_r.valid)
    else $error("output not valid after seven cycles");
  sleep_hold_a: assert property (
    clk_off && !rst_eff |=> $stable(s_r.acc) && $stable(s_r.phase_out))
    else $error("accumulator moved while clock off");
  pin_freq_a: assert property (
    pin_mode && fpin_s && !rst_eff && !clk_off |=>
    s_r.acc == $past(s_r.acc) + $past(s_r.f1))
    else $error("pin frequency pick ignored");
  sleep_pin_a: assert property (
    pin_mode && spin_s |=> converter_off ##1 1'b1)
    else $error("sleep pin did not power down");
  square_gate_a: assert property (
    !s_r.ctrl[dds_pkg::CB_SQEN] |=> !square_oe)
    else $error("square driven while disabled");
  full_cov: cover property (w_stb && s_r.pend ##1 !s_r.pend);
  release_cov: cover property ($fell(rst_eff) ##[1:20] $rose(s_r.valid));
  sleep_cov: cover property (clk_off ##1 !clk_off);
  square_cov: cover property (square_oe && square_out);
endmodule

// File: dds_host_model.sv
// Host model: frames serial words for the decoder
`timescale 1ns/1ps
module dds_host_model (
  input wire logic pclk,
  output logic serial_clk,
  output logic frame_sync,
  output logic serial_in
);
  // Idle link: clock high, frame high
  initial begin
    serial_clk = 1'b1;
    frame_sync = 1'b1;
    serial_in = 1'b0;
  end
  // framed word
  // Frame stays low for all 16 bits, MSB first, 170 ns clock
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      frame_sync <= 1'b0;
      serial_in <= w[i];
      repeat (8) @(posedge pclk);
      serial_clk <= 1'b0;
      repeat (8) @(posedge pclk);
      serial_clk <= 1'b1;
    end
    @(posedge pclk);
    frame_sync <= 1'b1;
    // Released line shows the inverse of the last bit
    serial_in <= ~w[0];
  endtask
endmodule

// File: dds_word_ctrl_tb_top.sv
// Self-checking bench for the word decoder and control block
`timescale 1ns/1ps
module dds_word_ctrl_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, serial_clk, frame_sync, serial_in;
  logic freq_pick_pin = 1'b0, phase_pick_pin = 1'b0;
  logic reset_pin = 1'b0, sleep_pin = 1'b0, comp_in = 1'b0;
  logic square_out, square_oe, converter_off, wave_valid;
  logic [11:0] phase_word, ph, p0, p1;
  logic [13:0] lo, hi;
  // Expected read results, error flag on top
  logic [32:0] exp_q[$];
  int n_fail = 0;
  int check_count = 0;
  int seed = 32'hb0fb;
  // Clock of 10 ns
  always #5 pclk = ~pclk;
  dds_word_ctrl i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .serial_clk, .frame_sync, .serial_in,
    .freq_pick_pin, .phase_pick_pin, .reset_pin, .sleep_pin, .comp_in,
    .square_out, .square_oe, .converter_off, .phase_word, .wave_valid);
  dds_host_model i_host (.pclk, .serial_clk, .frame_sync, .serial_in);
  // Compare and count
  task automatic chk(input logic [32:0] got, input logic [32:0] x);
    check_count++;
    if (got !== x) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, x);
    end
  endtask
  // Read results meet the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  end
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  // Command word over the register bus
  task automatic cw(input logic [15:0] w);
    apb(1'b1, dds_pkg::ADDR_WORD, {16'h0, w});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #300000;
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(dds_pkg::ADDR_CTRL, 33'h0); // reset word
    rd(8'h18, 33'h100000000);
    apb(1'b1, dds_pkg::ADDR_CTRL, 32'hffff);
    rd(dds_pkg::ADDR_STAT, 33'h80); // valid out
    $display("test 1 done");
    lo = 14'($random(seed));
    hi = 14'($random(seed));
    cw(16'h2000);
    i_host.send_word({2'b01, lo});
    rd(dds_pkg::ADDR_TUNING_WORD_ZERO, 33'h0); // staged half
    rd(dds_pkg::ADDR_STAT, 33'hc0); // pending
    i_host.send_word({2'b01, hi});
    rd(dds_pkg::ADDR_TUNING_WORD_ZERO, {5'h0, hi, lo}); // full word
    cw(16'h0000);
    i_host.send_word({2'b10, lo});
    i_host.send_word(16'h1000);
    rd(dds_pkg::ADDR_CTRL, 33'h1000); // serial control
    i_host.send_word({2'b10, hi});
    rd(dds_pkg::ADDR_TUNING_WORD_ONE, {5'h0, hi, lo}); // halves
    p0 = 12'($random(seed));
    p1 = 12'($random(seed));
    i_host.send_word({4'hc, p0});
    i_host.send_word({4'hf, p1});
    rd(dds_pkg::ADDR_PHASE, {5'h0, p1, 4'h0, p0}); // phase load
    $display("test 2 done");
    cw(16'h0c00);
    rd(dds_pkg::ADDR_STAT, 33'h86); // bit picks
    freq_pick_pin <= 1'b1;
    cw(16'h0200);
    rd(dds_pkg::ADDR_STAT, 33'h83); // pin pick
    freq_pick_pin <= 1'b0;
    phase_pick_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(dds_pkg::ADDR_STAT, 33'h85); // pin pick
    $display("test 3 done");
    reset_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({wave_valid, phase_word}, 33'h0); // pin reset
    rd(dds_pkg::ADDR_STAT, 33'h0d); // reset source
    reset_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(wave_valid, 1'b0); // release delay
    repeat (10) @(posedge pclk);
    chk(wave_valid, 1'b1); // output back
    rd(dds_pkg::ADDR_TUNING_WORD_ZERO, {5'h0, hi, lo}); // registers kept
    cw(16'h0100);
    rd(dds_pkg::ADDR_STAT, 33'h08); // bit reset
    cw(16'h0000);
    $display("test 4 done");
    cw(16'h0080);
    repeat (3) @(posedge pclk);
    ph = phase_word;
    i_host.send_word({4'hc, p1});
    chk(phase_word, ph); // frozen output
    rd(dds_pkg::ADDR_PHASE, {5'h0, p1, 4'h0, p1}); // writes in sleep
    cw(16'h0040);
    repeat (20) @(posedge pclk);
    chk(phase_word !== ph, 1'b1); // clock resumes
    chk(converter_off, 1'b1); // bit sleep
    cw(16'h0200);
    sleep_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(converter_off, 1'b1); // pin sleep
    sleep_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(converter_off, 1'b0); // pin release
    $display("test 5 done");
    cw(16'h0000);
    repeat (3) @(posedge pclk);
    chk(square_oe, 1'b0); // undriven
    // triangle bit kept low with square on
    cw(16'h0038);
    for (int i = 0; i < 8; i++) begin
      comp_in <= 1'($random(seed));
      repeat (5) @(posedge pclk);
      chk({square_oe, square_out}, {1'b1, comp_in}); // comparator
    end
    // Core frozen so the raw top bit stands still
    cw(16'h00a8);
    repeat (4) @(posedge pclk);
    chk({square_oe, square_out}, {1'b1, phase_word[11]}); // raw top bit
    $display("test 6 done");
    final_report();
  end
endmodule
